// file: src/mps_pkg.sv
// shared constants and types of the multiphase pulse sequencer
package mps_pkg;
	// ---------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------
	localparam int          CLK_NS       = 10;      // sys_clk period
	localparam int          SW_PERIOD_NS = 1000;    // default switching period
	localparam logic [15:0] PERIOD_RST   = 16'(SW_PERIOD_NS / CLK_NS);
	localparam int          SS_STEP_NS   = 2000;    // preset soft-start step
	localparam logic [15:0] SS_PRESET    = 16'(SS_STEP_NS / CLK_NS);
	localparam logic [15:0] SS_DIV_RST   = 16'h00c8; // resistor-set step
	localparam logic [7:0]  SS_LAST      = 8'hff;    // final ramp level
	// ---------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD  = 8'h04;
	localparam logic [7:0]  ADDR_SSDIV   = 8'h08;
	localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
	localparam int          CTRL_RUN     = 0;        // software run enable
	localparam int          CTRL_ALIGN   = 1;        // transient alignment enable
	localparam logic [1:0]  CTRL_RST     = 2'h3;
	localparam int          ST_POWER_OK_FLAG     = 0;
	localparam int          ST_SSDONE    = 1;
	localparam int          ST_RUN       = 2;
	localparam int          ST_CHAN      = 4;        // 3-bit channel count
	localparam int          ST_DT        = 8;
	localparam int          ST_OVP       = 9;        // 2-bit trip code
	localparam int          ST_FAM       = 11;
	// ---------------------------------------------------------
	// overvoltage trip codes
	// ---------------------------------------------------------
	localparam logic [1:0]  OVP_175      = 2'h0;
	localparam logic [1:0]  OVP_250      = 2'h1;
	localparam logic [1:0]  OVP_350      = 2'h2;
	// ---------------------------------------------------------
	// synchroniser bit positions
	// ---------------------------------------------------------
	localparam int          SY_CROSS     = 0;        // 4 bits
	localparam int          SY_TRANS     = 4;
	localparam int          SY_OV        = 5;
	localparam int          SY_UV        = 6;
	localparam int          SY_OC        = 7;
	localparam int          SY_EN        = 8;
	localparam int          SY_PH4RDY    = 9;
	localparam int          SY_PH4OFF    = 10;
	localparam int          SY_SUP3      = 11;
	localparam int          SY_OVERVOLTAGE_TRIP_SELECT    = 12;
	localparam int          SY_DTSEL     = 13;
	localparam int          SY_FAM       = 14;
	localparam int          SY_UOFF      = 15;       // 3 bits
	localparam int          SY_LNODE     = 18;       // 3 bits
	localparam int          SY_LOWER_GATE_DRIVE     = 21;       // 3 bits
	localparam int          SYNC_W       = 24;
	// soft-start states
	typedef enum logic [2:0] {
		SS_IDLE = 3'b001,
		SS_RAMP = 3'b010,
		SS_DONE = 3'b100
	} mps_ss_type;
endpackage

// file: src/mps_channel.sv
// one channel: windowed pulse latch and gate sequencing
`timescale 1ns/1ps
module mps_channel #(
	parameter bit HAS_GATES = 1'b1
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// sequencing from the core
	input  wire logic chanEnable,
	input  wire logic windowStart,
	input  wire logic rampCross,
	input  wire logic alignNow,
	// synchronised gate feedback
	input  wire logic upperOffSeen,
	input  wire logic lowerOffSeen,
	// outputs, all from flops
	output logic      pulseOut,
	output logic      upperGate,
	output logic      lowerGate
);
	typedef struct packed {
		logic pwm;   // channel pulse
		logic armed; // a rise is still allowed in this window
		logic upper; // upper transistor command
		logic lower; // lower transistor command
	} mps_chan_type;

	mps_chan_type r;
	mps_chan_type n;
	logic         canRise;

	// ---------------------------------------------------------
	// next state
	// ---------------------------------------------------------
	always_comb begin
		n       = r;
		canRise = r.armed | windowStart;
		if (!chanEnable) begin
			// idle channel: both transistors off
			n = '0;
		end else begin
			if (!r.pwm && canRise && (rampCross || alignNow)) begin
				n.pwm   = 1'b1;
				n.armed = 1'b0;
			end else if (r.pwm && !rampCross && !alignNow) begin
				n.pwm = 1'b0;
				n.armed = canRise;
			end else begin
				// holds: low with no allowed rise, high while crossed or aligned
				n.armed = canRise;
			end
			if (HAS_GATES) begin
				if (r.pwm) begin
					// lower off first, upper only once lower is seen off
					n.lower = 1'b0;
					n.upper = r.upper | (!r.lower && lowerOffSeen);
				end else begin
					n.upper = 1'b0;
					n.lower = r.lower | (!r.upper && upperOffSeen);
				end
			end else begin
				n.upper = 1'b0;
				n.lower = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pulseOut  = r.pwm;
	assign upperGate = r.upper;
	assign lowerGate = r.lower;

	// ---------------------------------------------------------
	// checks
	// ---------------------------------------------------------
	AST_ONE_RISE: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(r.pwm) |-> ($past(r.armed) || $past(windowStart)) && !r.armed)
		else $error("pulse rose without an open window");
	AST_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!r.pwm && !rampCross && !alignNow) |=> !r.pwm)
		else $error("pulse rose while below ramp");
	AST_NO_SHOOT: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(r.upper && r.lower))
		else $error("both gates on");
	AST_UPPER_WAIT: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(r.upper) |-> $past(lowerOffSeen) && $past(r.pwm) && !$past(r.lower))
		else $error("upper on before lower seen off");
	AST_LOWER_WAIT: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(r.lower) |-> $past(upperOffSeen) && !$past(r.pwm))
		else $error("lower on before upper seen off");
	AST_LOW_UPPER_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
		!r.pwm |=> !r.upper)
		else $error("upper on while pulse low");
endmodule

// file: src/mps_sequencer.sv
// multiphase pulse sequencer core with straps, soft-start and register slave
// Contract
// - three channels spaced one third period
// - window period from programmed switching period
// - pulse low while below ramp
// - pulse high at crossing, low at next
// - one rising edge per window
// - pulse low lower on, high upper on
// - transient turns all active phases on; code turns on only phases with no rise yet in their current window
// - upper gate monitored against shoot-through
// - fourth pulse output drives external driver
// - fourth-phase pin high gives three phases
// - fourth-phase pin threshold gates power-up
// - trip select gives 175/250/350 mV code
// - dead-time pin picks detection scheme
// - soft-start step resistor-set or preset
// - power ok low until soft-start done
// - enable pin halts or allows operation
// - missing third supply gives two phases
`timescale 1ns/1ps
module mps_sequencer (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// analog comparator and fault levels (asynchronous)
	input  wire logic [3:0]  rampCross,
	input  wire logic        transientDetect,
	input  wire logic        overVoltage,
	input  wire logic        underVoltage,
	input  wire logic        overCurrent,
	input  wire logic        enableLevel,
	// straps (asynchronous)
	input  wire logic        fourthChannelEnableSync,
	input  wire logic        fourthChannelTiedHigh,
	input  wire logic        thirdDriverSupply,
	input  wire logic        overvoltageTripSelect,
	input  wire logic        deadTimeSelect,
	input  wire logic        dacFamilyB,
	// gate feedback (asynchronous)
	input  wire logic [2:0]  upperGateOff,
	input  wire logic [2:0]  switchNodeLow,
	input  wire logic [2:0]  lowerGateOff,
	// power stage
	output logic      [2:0]  upperGateDrive,
	output logic      [2:0]  lowerGateDrive,
	output logic             fourthChannelPulseOut,
	// analog side controls
	output logic      [3:0]  windowStart,
	output logic      [7:0]  softStartLevel,
	output logic      [1:0]  overvoltageTripCode,
	output logic             deadTimeLowerGate,
	output logic             powerOkFlag
);
	// ---------------------------------------------------------
	// state
	// ---------------------------------------------------------
	typedef struct packed {
		logic [mps_pkg::SYNC_W-1:0] sync1;    // first stage, read by sync2 only
		logic [mps_pkg::SYNC_W-1:0] sync2;    // safe copies
		logic [1:0]                 ctrl;     // run and align enables
		logic [15:0]                period;   // cycles per switching period
		logic [15:0]                ssDiv;    // resistor-set soft-start step
		logic                       aValid;   // pending data phase
		logic                       aWrite;
		logic [7:0]                 aAddr;
		logic [31:0]                rdata;
		logic                       readyOut;
		logic [15:0]                slotCnt;  // cycles inside a slot
		logic [1:0]                 slotIdx;  // channel owning the slot
		logic [3:0]                 winStart; // window start pulses
		logic [2:0]                 chanCount;
		logic [1:0]                 ovpCode;
		logic                       dtGate;
		logic                       famB;
		logic                       running;
		mps_pkg::mps_ss_type        ssState;
		logic [15:0]                ssCnt;
		logic [7:0]                 ssLevel;
		logic                       powerOk;
	} mps_core_type;

	mps_core_type r;
	mps_core_type n;

	// ---------------------------------------------------------
	// combinational helpers
	// ---------------------------------------------------------
	logic [mps_pkg::SYNC_W-1:0] pins;     // raw asynchronous inputs
	logic [3:0]                 chEnable; // channel active
	logic [3:0]                 pulse;    // channel pulses
	logic [3:0]                 upG;
	logic [3:0]                 loG;
	logic [3:0]                 upOff;    // synchronised upper-off feedback
	logic [3:0]                 loOff;    // selected lower-off feedback
	logic [15:0]                slotLen;  // period divided by channel count
	logic [15:0]                ssStep;   // active soft-start step
	logic                       runOk;    // all run conditions met
	logic                       alignNow;
	logic                       addrPhase;
	logic [31:0]                rd;       // read mux
	logic [2:0]                 cnt;      // channel count from straps

	assign pins = {lowerGateOff, switchNodeLow, upperGateOff, dacFamilyB,
		deadTimeSelect, overvoltageTripSelect, thirdDriverSupply,
		fourthChannelTiedHigh, fourthChannelEnableSync, enableLevel,
		overCurrent, underVoltage, overVoltage, transientDetect, rampCross};

	// channel count: missing supply, then fourth-phase pin
	always_comb begin
		if (!r.sync2[mps_pkg::SY_SUP3]) begin
			cnt = 3'h2;
		end else if (r.sync2[mps_pkg::SY_PH4OFF]) begin
			cnt = 3'h3;
		end else begin
			cnt = 3'h4;
		end
	end

	// slot length; a remainder of the period is dropped
	always_comb begin
		unique case (r.chanCount)
			3'h2:    slotLen = r.period >> 1;
			3'h3:    slotLen = r.period / 16'h0003;
			default: slotLen = r.period >> 2;
		endcase
		if (slotLen == 16'h0000) begin
			slotLen = 16'h0001; // tiny periods still step
		end
	end

	// soft-start step: resistor value or preset by family
	assign ssStep = r.famB ? mps_pkg::SS_PRESET : r.ssDiv;

	// run needs software, enable pin, driver sync and no overcurrent
	assign runOk = r.ctrl[mps_pkg::CTRL_RUN] && r.sync2[mps_pkg::SY_EN]
		&& r.sync2[mps_pkg::SY_PH4RDY] && !r.sync2[mps_pkg::SY_OC];

	assign alignNow = r.ctrl[mps_pkg::CTRL_ALIGN] && r.sync2[mps_pkg::SY_TRANS];

	assign addrPhase = hsel && htrans[1] && hready;

	// channel enables and feedback selection
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			chEnable[i] = r.running && (3'(i) < r.chanCount);
		end
		upOff = {1'b1, r.sync2[mps_pkg::SY_UOFF +: 3]};
		if (r.dtGate) begin
			loOff = {1'b1, r.sync2[mps_pkg::SY_LOWER_GATE_DRIVE +: 3]};
		end else begin
			loOff = {1'b1, r.sync2[mps_pkg::SY_LNODE +: 3]};
		end
	end

	// read mux, with forwarding of a write in its data phase
	always_comb begin
		rd = 32'h0000_0000;
		unique case (haddr[7:0])
			mps_pkg::ADDR_CTRL:   rd[1:0] = r.ctrl;
			mps_pkg::ADDR_PERIOD: rd[15:0] = r.period;
			mps_pkg::ADDR_SSDIV:  rd[15:0] = r.ssDiv;
			mps_pkg::ADDR_STATUS: begin
				rd[mps_pkg::ST_POWER_OK_FLAG]     = r.powerOk;
				rd[mps_pkg::ST_SSDONE]    = (r.ssState == mps_pkg::SS_DONE);
				rd[mps_pkg::ST_RUN]       = r.running;
				rd[mps_pkg::ST_CHAN +: 3] = r.chanCount;
				rd[mps_pkg::ST_DT]        = r.dtGate;
				rd[mps_pkg::ST_OVP +: 2]  = r.ovpCode;
				rd[mps_pkg::ST_FAM]       = r.famB;
			end
			default: rd = 32'h0000_0000; // unmapped reads zero
		endcase
		if (r.aValid && r.aWrite && (r.aAddr == haddr[7:0])
			&& (haddr[31:8] == 24'h000000)) begin
			unique case (haddr[7:0])
				mps_pkg::ADDR_CTRL:   rd = {30'h0, hwdata[1:0]};
				mps_pkg::ADDR_PERIOD: rd = {16'h0, hwdata[15:0]};
				mps_pkg::ADDR_SSDIV:  rd = {16'h0, hwdata[15:0]};
				default: ;
			endcase
		end
		if (haddr[31:8] != 24'h000000) begin
			rd = 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------
	// next state
	// ---------------------------------------------------------
	always_comb begin
		n          = r;
		n.sync1    = pins;
		n.sync2    = r.sync1;
		n.readyOut = 1'b1; // zero wait states
		// bus address phase
		n.aValid = addrPhase;
		n.aWrite = hwrite;
		n.aAddr  = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
		if (addrPhase && !hwrite) begin
			n.rdata = rd;
		end
		// bus data phase write
		if (r.aValid && r.aWrite) begin
			unique case (r.aAddr)
				mps_pkg::ADDR_CTRL:   n.ctrl = hwdata[1:0];
				mps_pkg::ADDR_PERIOD: n.period = hwdata[15:0];
				mps_pkg::ADDR_SSDIV:  n.ssDiv = hwdata[15:0];
				default: ; // status and unmapped ignore writes
			endcase
		end
		// straps follow the pins only while stopped
		if (!r.running) begin
			n.chanCount = cnt;
			n.dtGate    = r.sync2[mps_pkg::SY_DTSEL];
			n.famB      = r.sync2[mps_pkg::SY_FAM];
			if (r.sync2[mps_pkg::SY_OVERVOLTAGE_TRIP_SELECT]) begin
				n.ovpCode = mps_pkg::OVP_350;
			end else if (r.sync2[mps_pkg::SY_FAM]) begin
				n.ovpCode = mps_pkg::OVP_250;
			end else begin
				n.ovpCode = mps_pkg::OVP_175;
			end
		end
		n.running = runOk;
		// slot timer: each channel owns one slot of period over N
		n.winStart = 4'h0;
		if (!r.running) begin
			n.slotCnt = 16'h0000;
			n.slotIdx = 2'h0;
		end else begin
			if (r.slotCnt == 16'h0000) begin
				n.winStart[r.slotIdx] = 1'b1;
			end
			if (r.slotCnt >= slotLen - 16'h0001) begin
				n.slotCnt = 16'h0000;
				if (3'({1'b0, r.slotIdx}) + 3'h1 >= r.chanCount) begin
					n.slotIdx = 2'h0;
				end else begin
					n.slotIdx = r.slotIdx + 2'h1;
				end
			end else begin
				n.slotCnt = r.slotCnt + 16'h0001;
			end
		end
		// soft-start sequence
		unique case (r.ssState)
			mps_pkg::SS_IDLE: begin
				n.ssCnt   = 16'h0000;
				n.ssLevel = 8'h00;
				if (runOk) begin
					n.ssState = mps_pkg::SS_RAMP;
				end
			end
			mps_pkg::SS_RAMP: begin
				if (r.ssCnt >= ssStep - 16'h0001) begin
					n.ssCnt   = 16'h0000;
					n.ssLevel = r.ssLevel + 8'h01;
					if (r.ssLevel + 8'h01 == mps_pkg::SS_LAST) begin
						n.ssState = mps_pkg::SS_DONE;
					end
				end else begin
					n.ssCnt = r.ssCnt + 16'h0001;
				end
			end
			mps_pkg::SS_DONE: ;
			default: n.ssState = mps_pkg::SS_IDLE; // illegal code recovers
		endcase
		// any stop, including an overcurrent, restarts the ramp
		if (!runOk) begin
			n.ssState = mps_pkg::SS_IDLE;
		end
		// power ok: done ramping and inside both limits
		n.powerOk = runOk && (r.ssState == mps_pkg::SS_DONE)
			&& !r.sync2[mps_pkg::SY_OV] && !r.sync2[mps_pkg::SY_UV];
	end

	// ---------------------------------------------------------
	// state register
	// ---------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r           <= '0;
			r.ctrl      <= mps_pkg::CTRL_RST;
			r.period    <= mps_pkg::PERIOD_RST;
			r.ssDiv     <= mps_pkg::SS_DIV_RST;
			r.chanCount <= 3'h2;
			r.ssState   <= mps_pkg::SS_IDLE;
			r.readyOut  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ---------------------------------------------------------
	// channels
	// ---------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : gCh
		mps_channel #(
			.HAS_GATES (g < 3)
		) uChan (
			.sys_clk      (sys_clk),
			.resetn       (resetn),
			.chanEnable   (chEnable[g]),
			.windowStart  (r.winStart[g]),
			.rampCross    (r.sync2[mps_pkg::SY_CROSS + g]),
			.alignNow     (alignNow),
			.upperOffSeen (upOff[g]),
			.lowerOffSeen (loOff[g]),
			.pulseOut     (pulse[g]),
			.upperGate    (upG[g]),
			.lowerGate    (loG[g])
		);
	end

	// outputs, all from flops except hresp, which is tied low
	assign upperGateDrive        = upG[2:0];
	assign lowerGateDrive        = loG[2:0];
	assign fourthChannelPulseOut = pulse[3];
	assign windowStart           = r.winStart;
	assign softStartLevel        = r.ssLevel;
	assign overvoltageTripCode   = r.ovpCode;
	assign deadTimeLowerGate     = r.dtGate;
	assign powerOkFlag           = r.powerOk;
	assign hrdata                = r.rdata;
	assign hreadyout             = r.readyOut;
	assign hresp                 = 1'b0;

	// ---------------------------------------------------------
	// checks
	// ---------------------------------------------------------
	AST_POWER_OK_FLAG_SS: assert property (@(posedge sys_clk) disable iff (!resetn)
		r.powerOk |-> $past(r.ssState) == mps_pkg::SS_DONE)
		else $error("power ok before soft-start end");
	AST_POWER_OK_FLAG_FAULT: assert property (@(posedge sys_clk) disable iff (!resetn)
		(r.sync2[mps_pkg::SY_OV] || r.sync2[mps_pkg::SY_UV] || r.sync2[mps_pkg::SY_OC])
		|=> !r.powerOk)
		else $error("power ok during fault");
	AST_PH4_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn)
		(r.chanCount != 3'h4) |=> !pulse[3])
		else $error("fourth pulse while not four-phase");
	AST_ENABLE_HALT: assert property (@(posedge sys_clk) disable iff (!resetn)
		!r.sync2[mps_pkg::SY_EN] |=> (!r.running && (chEnable == 4'h0)) ##1 (r.winStart == 4'h0))
		else $error("running with enable low");
	AST_WIN_ONE: assert property (@(posedge sys_clk) disable iff (!resetn)
		$onehot0(r.winStart) && ((r.winStart & ~chEnable) == 4'h0 || !r.running))
		else $error("bad window start");
	AST_OVP_HIGH: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!r.running && r.sync2[mps_pkg::SY_OVERVOLTAGE_TRIP_SELECT]) |=> r.ovpCode == mps_pkg::OVP_350)
		else $error("trip code not 350");
endmodule

// file: test/mps_power_stage_model.sv
// power stage model: gate commands in, delayed transistor-off feedback out
`timescale 1ns/1ps
module mps_power_stage_model (
	// clock and speed select
	input  wire logic       sys_clk,
	input  wire logic       slow,
	// gate commands
	input  wire logic [2:0] upperGateDrive,
	input  wire logic [2:0] lowerGateDrive,
	// transistor-off feedback
	output logic      [2:0] upperGateOff,
	output logic      [2:0] switchNodeLow,
	output logic      [2:0] lowerGateOff
);
	logic [3:0][2:0] upHist = '0; // upper command history
	logic [3:0][2:0] loHist = '0; // lower command history
	logic      [2:0] upSlow;      // extra discharge time
	logic      [2:0] loSlow;
	// ------------------------------
	// gate discharge delay
	// ------------------------------
	always @(posedge sys_clk) begin
		upHist <= {upHist[2:0], upperGateDrive};
		loHist <= {loHist[2:0], lowerGateDrive};
	end
	assign upSlow = slow ? (upHist[1] | upHist[2] | upHist[3]) : 3'h0;
	assign loSlow = slow ? (loHist[1] | loHist[2] | loHist[3]) : 3'h0;
	// reports off only once the gate stayed low the whole delay, never early
	assign upperGateOff = ~(upperGateDrive | upHist[0] | upSlow);
	assign lowerGateOff = ~(lowerGateDrive | loHist[0] | loSlow);
	// both detection schemes see the same transistor here
	assign switchNodeLow = lowerGateOff;
endmodule

// file: test/test_mps_sequencer.sv
// self-checking testbench of the multiphase pulse sequencer
`timescale 1ns/1ps
module test_mps_sequencer;
	logic        sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, slow = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]  htrans = 0, overvoltageTripCode;
	logic [3:0]  rampCross = 0, windowStart;
	logic [2:0]  upperGateOff, switchNodeLow, lowerGateOff, upperGateDrive, lowerGateDrive;
	logic        transientDetect = 0, overVoltage = 0, underVoltage = 0, overCurrent = 0;
	logic        enableLevel = 1, fourthChannelEnableSync = 1, fourthChannelTiedHigh = 1;
	logic        thirdDriverSupply = 1, overvoltageTripSelect = 0, deadTimeSelect = 0;
	logic        dacFamilyB = 0, fourthChannelPulseOut, deadTimeLowerGate, powerOkFlag;
	logic [7:0]  softStartLevel;
	int          failures = 0, n_compared = 0, cycles = 0, g;
	// ------------------------------
	// design and power stage
	// ------------------------------
	mps_sequencer u_mps_sequencer (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rampCross,
		.transientDetect, .overVoltage, .underVoltage, .overCurrent, .enableLevel,
		.fourthChannelEnableSync, .fourthChannelTiedHigh, .thirdDriverSupply,
		.overvoltageTripSelect, .deadTimeSelect, .dacFamilyB, .upperGateOff, .switchNodeLow,
		.lowerGateOff, .upperGateDrive, .lowerGateDrive, .fourthChannelPulseOut,
		.windowStart, .softStartLevel, .overvoltageTripCode, .deadTimeLowerGate, .powerOkFlag);
	mps_power_stage_model u_mps_power_stage_model (.sys_clk, .slow, .upperGateDrive,
		.lowerGateDrive, .upperGateOff, .switchNodeLow, .lowerGateOff);
	// ------------------------------
	// clock, timeout, helpers
	// ------------------------------
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize;
		if (failures == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		n_compared++;
		if (v !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// cycles until the next window start of channel k
	task automatic gap(input int k, output int n);
		n = 0;
		do begin cyc(1); n++; end while (windowStart[k] !== 1'b1 && n < 300);
	endtask
	// wait bounded for channel 0 gates {upper, lower}
	task automatic wg(input logic [1:0] e);
		int n = 0;
		while ({upperGateDrive[0], lowerGateDrive[0]} !== e && n < 20) begin cyc(1); n++; end
		chk("gates0", {30'h0, e}, {30'h0, upperGateDrive[0], lowerGateDrive[0]});
	endtask
	// cycles until the soft-start level moves
	task automatic step(output int n);
		logic [7:0] v = softStartLevel;
		n = 0;
		while (softStartLevel === v && n < 500) begin cyc(1); n++; end
	endtask
	task automatic waitOk;
		int n = 0;
		while (powerOkFlag !== 1'b1 && n < 1500) begin
			cyc(1);
			n++;
			if (powerOkFlag === 1'b1 && softStartLevel !== 8'hff) chk("early ok", 0, 1);
		end
		chk("ok", 32'h1ff, {softStartLevel, powerOkFlag});
	endtask
	// shoot-through watch on every cycle
	always @(negedge sys_clk) if (resetn) chk("overlap", 0, upperGateDrive & lowerGateDrive);
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic regsAndStraps;
		logic [31:0] e [4] = '{32'h3, 32'h64, 32'hc8, 32'h0};
		bus(1'b1, 8'h40, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, (i < 3) ? 8'(i * 4) : 8'h40, 32'h0);
			chk("register", e[i], q);
		end
		bus(1'b1, 8'h00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			overvoltageTripSelect <= i[1];
			dacFamilyB <= i[0];
			deadTimeSelect <= i[0];
			cyc(5);
			chk("trip", i[1] ? 2'h2 : {1'b0, i[0]}, overvoltageTripCode);
			chk("deadtime", i[0], deadTimeLowerGate);
		end
		@(posedge sys_clk) dacFamilyB <= 1'b0;
	endtask
	task automatic phases;
		for (int n = 2; n <= 4; n++) begin
			bus(1'b1, 8'h00, 32'h0);
			@(posedge sys_clk);
			thirdDriverSupply <= (n != 2);
			fourthChannelTiedHigh <= (n != 4);
			rampCross <= 4'h8;
			cyc(5);
			bus(1'b1, 8'h04, 32'h18);
			bus(1'b1, 8'h00, 32'h3);
			bus(1'b0, 8'h0c, 32'h0);
			chk("count", n, q[6:4]);
			gap(0, g);
			for (int k = 1; k <= n; k++) begin
				gap(k % n, g);
				chk("slot", 24 / n, g);
			end
			chk("pulse4", n == 4, fourthChannelPulseOut);
		end
		@(posedge sys_clk) rampCross <= 4'h0;
	endtask
	task automatic oneRiseAndAlign;
		slow <= 1'b1;
		bus(1'b1, 8'h04, 32'ha0);
		gap(0, g);
		wg(2'b01);
		@(posedge sys_clk) rampCross <= 4'h1;
		wg(2'b10);
		@(posedge sys_clk) rampCross <= 4'h0;
		wg(2'b01);
		@(posedge sys_clk) rampCross <= 4'h1;
		g = 0;
		for (int n = 0; windowStart[0] !== 1'b1 && n < 200; n++) begin
			cyc(1);
			g = g | upperGateDrive[0];
		end
		chk("second rise", 0, g);
		wg(2'b10);
		@(posedge sys_clk) rampCross <= 4'h0;
		wg(2'b01);
		gap(0, g);
		@(posedge sys_clk) transientDetect <= 1'b1;
		for (int n = 0; upperGateDrive !== 3'h7 && n < 30; n++) cyc(1);
		chk("aligned", 4'hf, {fourthChannelPulseOut, upperGateDrive});
		@(posedge sys_clk) transientDetect <= 1'b0;
		cyc(30);
		chk("released", 0, {fourthChannelPulseOut, upperGateDrive});
		slow <= 1'b0;
	endtask
	task automatic softStartAndFaults;
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h08, 32'h2);
		bus(1'b1, 8'h00, 32'h3);
		step(g);
		step(g);
		chk("step", 2, g);
		waitOk();
		for (int f = 0; f < 3; f++) begin
			@(posedge sys_clk) {overCurrent, underVoltage, overVoltage} <= 3'(1 << f);
			cyc(4);
			chk("fault ok", 0, powerOkFlag);
			@(posedge sys_clk) {overCurrent, underVoltage, overVoltage} <= 3'h0;
			waitOk();
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			enableLevel <= i[0];
			fourthChannelEnableSync <= !i[0];
			cyc(6);
			g = 0;
			for (int n = 0; n < 200; n++) begin
				cyc(1);
				g = g + windowStart[0] + powerOkFlag;
			end
			chk("halted", 0, g);
			@(posedge sys_clk) {enableLevel, fourthChannelEnableSync} <= 2'h3;
		end
		bus(1'b1, 8'h00, 32'h0);
		@(posedge sys_clk) dacFamilyB <= 1'b1;
		cyc(5);
		bus(1'b1, 8'h00, 32'h3);
		step(g);
		step(g);
		chk("preset step", mps_pkg::SS_PRESET, g);
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		chk("reset", 32'h1, {upperGateDrive, lowerGateDrive, windowStart, powerOkFlag, hreadyout});
		resetn <= 1'b1;
		regsAndStraps();
		phases();
		oneRiseAndAlign();
		softStartAndFaults();
		summarize();
	end
endmodule
